// >>> include/iis_pkg.sv
`default_nettype none
package iis_pkg;
  // Target addresses selected by the address-select strap
  localparam logic [6:0] ADDR_SEL_LOW = 7'h68;
  localparam logic [6:0] ADDR_SEL_HIGH = 7'h69;
  localparam logic [7:0] START_ADDR_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  // Watchdog periods in microseconds and cycles at 25 MHz
  localparam int CLK_MHZ = 25;
  localparam int WDT_SHORT_US = 1250;
  localparam int WDT_LONG_US = 40000;
  localparam int WDT_SHORT_CYC = WDT_SHORT_US * CLK_MHZ;
  localparam int WDT_LONG_CYC = WDT_LONG_US * CLK_MHZ;
  // Host idle times after a write, for reference by the bench
  localparam int IDLE_NORMAL_US = 2;
  localparam int IDLE_SUSPEND_US = 450;
  localparam int IDLE_NORMAL_CYC = IDLE_NORMAL_US * CLK_MHZ;
  localparam int IDLE_SUSPEND_CYC = IDLE_SUSPEND_US * CLK_MHZ;
  localparam logic [2:0] BIT_LAST = 3'h7;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DEVADDR = 3'h1,
    ST_ACK = 3'h3,
    ST_RX = 3'h2,
    ST_TX = 3'h6,
    ST_MACK = 3'h7,
    ST_IGNORE = 3'h5
  } iis_state_type;
endpackage : iis_pkg
`default_nettype wire

// >>> verilog/iis_bus_watch.sv
`default_nettype none
// Bus event detector: start, stop, SCL rising and falling edges
module iis_bus_watch (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic start_o,
  output logic stop_o,
  output logic scl_rise_o,
  output logic scl_fall_o
);
  logic scl_ff;
  logic sda_ff;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_ff <= 1'h1;
      sda_ff <= 1'h1;
    end else if (ce_i) begin
      scl_ff <= scl_i;
      sda_ff <= sda_i;
    end
  end

  assign start_o = scl_ff & scl_i & sda_ff & ~sda_i;
  assign stop_o = scl_ff & scl_i & ~sda_ff & sda_i;
  assign scl_rise_o = ~scl_ff & scl_i;
  assign scl_fall_o = scl_ff & ~scl_i;
endmodule : iis_bus_watch
`default_nettype wire

// >>> verilog/iis_target.sv
// How it works
// - Start, 7-bit address, write bit zero; we acknowledge then release SDA.
// - Register address byte then data byte, each acknowledged; data is stored.
// - More write bytes accepted; address advances except on trap registers.
// - Controller ack low asks for more; not-ack makes us release the bus.
// - Register address increments after each returned byte.
// - Each read starts at the last written start address; zero after reset.
// - Watchdog resets the port when we hold SDA low too long.
// - Address 0x68 with select pin low, 0x69 high; 7-bit only.
`default_nettype none
module iis_target #(
  parameter int WDT_SHORT = iis_pkg::WDT_SHORT_CYC,
  parameter int WDT_LONG = iis_pkg::WDT_LONG_CYC,
  parameter logic [255:0] TRAP_MASK = 256'h0
) (
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  input wire logic ADDR_SEL_I,
  input wire logic WDT_EN_I,
  input wire logic WDT_SEL_I,
  input wire logic [7:0] RD_DATA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  output logic [7:0] REG_ADDR_O,
  output logic [7:0] WR_DATA_O,
  output logic WR_STB_O,
  output logic RD_STB_O,
  output logic WDT_FIRE_O
);
  // ==========================================
  // Bus events
  logic start_ev;
  logic stop_ev;
  logic rise_ev;
  logic fall_ev;

  iis_bus_watch u_watch (
    .clk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .ce_i(CE_I),
    .scl_i(SCL_I),
    .sda_i(SDA_I),
    .start_o(start_ev),
    .stop_o(stop_ev),
    .scl_rise_o(rise_ev),
    .scl_fall_o(fall_ev)
  );

  function automatic logic [7:0] next_addr(input logic [7:0] a, input logic [255:0] trap);
    next_addr = trap[a] ? a : a + 8'h01;
  endfunction

  // ==========================================
  // State
  iis_pkg::iis_state_type state_ff;
  logic [7:0] shift_ff;
  logic [2:0] bit_ff;
  logic rw_ff;
  logic have_reg_ff;
  logic drive_low_ff;
  logic [7:0] addr_ff;
  logic [31:0] wdt_ff;
  logic wdt_rst;
  logic [6:0] my_addr;
  logic seen_rise_ff;
  logic [7:0] start_ff;
  logic byte_done;
  logic set_start;

  assign my_addr = ADDR_SEL_I ? iis_pkg::ADDR_SEL_HIGH : iis_pkg::ADDR_SEL_LOW;
  assign wdt_rst = WDT_EN_I && (wdt_ff >= (WDT_SEL_I ? 32'(WDT_LONG) : 32'(WDT_SHORT)));
  assign byte_done = fall_ev && seen_rise_ff && (bit_ff == iis_pkg::BIT_LAST);
  // Register address byte of a write phase completes
  assign set_start = !wdt_rst && !stop_ev && !start_ev && byte_done &&
                     (state_ff == iis_pkg::ST_RX) && !have_reg_ff;

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_ff <= iis_pkg::ST_IDLE;
      bit_ff <= 3'h0;
      shift_ff <= iis_pkg::DATA_RST;
      rw_ff <= 1'h0;
      have_reg_ff <= 1'h0;
      drive_low_ff <= 1'h0;
      seen_rise_ff <= 1'h0;
      addr_ff <= iis_pkg::START_ADDR_RST;
      WR_STB_O <= 1'h0;
      RD_STB_O <= 1'h0;
      WR_DATA_O <= iis_pkg::DATA_RST;
    end else if (CE_I) begin
      WR_STB_O <= 1'h0;
      RD_STB_O <= 1'h0;
      if (wdt_rst || stop_ev) begin
        state_ff <= iis_pkg::ST_IDLE;
        drive_low_ff <= 1'h0;
      end else if (start_ev) begin
        state_ff <= iis_pkg::ST_DEVADDR;
        bit_ff <= 3'h0;
        seen_rise_ff <= 1'h0;
        drive_low_ff <= 1'h0;
      end else begin
        unique case (state_ff)
          iis_pkg::ST_IDLE, iis_pkg::ST_IGNORE: begin
          end
          iis_pkg::ST_DEVADDR, iis_pkg::ST_RX: begin
            if (rise_ev) begin
              shift_ff <= {shift_ff[6:0], SDA_I};
              seen_rise_ff <= 1'h1;
            end
            // The SCL fall right after a start carries no bit
            if (fall_ev && seen_rise_ff) begin
              seen_rise_ff <= 1'h0;
              bit_ff <= bit_ff + 3'h1;
              if (byte_done) begin
                if (state_ff == iis_pkg::ST_DEVADDR) begin
                  if (shift_ff[7:1] == my_addr) begin
                    rw_ff <= shift_ff[0];
                    if (shift_ff[0]) begin
                      addr_ff <= start_ff;
                    end
                    have_reg_ff <= 1'h0;
                    drive_low_ff <= 1'h1;
                    state_ff <= iis_pkg::ST_ACK;
                  end else begin
                    state_ff <= iis_pkg::ST_IGNORE;
                  end
                end else begin
                  if (!have_reg_ff) begin
                    addr_ff <= shift_ff;
                    have_reg_ff <= 1'h1;
                  end else begin
                    WR_DATA_O <= shift_ff;
                    WR_STB_O <= 1'h1;
                  end
                  drive_low_ff <= 1'h1;
                  state_ff <= iis_pkg::ST_ACK;
                end
              end
            end
          end
          iis_pkg::ST_ACK: begin
            if (fall_ev) begin
              bit_ff <= 3'h0;
              if (rw_ff) begin
                shift_ff <= RD_DATA_I;
                drive_low_ff <= ~RD_DATA_I[7];
                RD_STB_O <= 1'h1;
                state_ff <= iis_pkg::ST_TX;
              end else begin
                drive_low_ff <= 1'h0;
                state_ff <= iis_pkg::ST_RX;
              end
            end
          end
          iis_pkg::ST_TX: begin
            if (fall_ev) begin
              bit_ff <= bit_ff + 3'h1;
              if (bit_ff == iis_pkg::BIT_LAST) begin
                drive_low_ff <= 1'h0;
                addr_ff <= next_addr(addr_ff, 256'h0);
                state_ff <= iis_pkg::ST_MACK;
              end else begin
                shift_ff <= {shift_ff[6:0], 1'h0};
                drive_low_ff <= ~shift_ff[6];
              end
            end
          end
          iis_pkg::ST_MACK: begin
            if (rise_ev) begin
              if (SDA_I) begin
                state_ff <= iis_pkg::ST_IGNORE;
              end else begin
                state_ff <= iis_pkg::ST_ACK;
              end
            end
          end
          default: state_ff <= iis_pkg::ST_IDLE;
        endcase
        if (WR_STB_O) begin
          addr_ff <= next_addr(addr_ff, TRAP_MASK);
        end
      end
    end
  end

  // ==========================================
  // Read start address, kept across reads
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      start_ff <= iis_pkg::START_ADDR_RST;
    end else if (CE_I) begin
      if (set_start) begin
        start_ff <= shift_ff;
      end
    end
  end

  // ==========================================
  // Watchdog on SDA held low by us
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wdt_ff <= 32'h0;
    end else if (CE_I) begin
      if (!drive_low_ff || rise_ev || fall_ev || wdt_rst) begin
        wdt_ff <= 32'h0;
      end else begin
        wdt_ff <= wdt_ff + 32'h1;
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      SDA_O <= 1'h0;
      SDA_OE_O <= 1'h0;
      REG_ADDR_O <= iis_pkg::START_ADDR_RST;
      WDT_FIRE_O <= 1'h0;
    end else if (CE_I) begin
      SDA_O <= 1'h0;
      SDA_OE_O <= drive_low_ff && !wdt_rst;
      REG_ADDR_O <= addr_ff;
      WDT_FIRE_O <= wdt_rst;
    end
  end
endmodule : iis_target
`default_nettype wire

// >>> tb/iis_target_properties.sv
`default_nettype none
module iis_target_properties #(
  parameter int WDT_SHORT = 50,
  parameter int WDT_LONG = 100
) (
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire logic SCL_I,
  input wire logic WDT_EN_I,
  input wire logic WDT_SEL_I,
  input wire logic SDA_O,
  input wire logic SDA_OE_O,
  input wire logic WR_STB_O,
  input wire logic RD_STB_O,
  input wire logic WDT_FIRE_O
);
  int hold_ff;
  int lim;
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RST_N_I);
  assign lim = WDT_SEL_I ? WDT_LONG : WDT_SHORT;
  // Cycles we hold SDA low with SCL still
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) hold_ff <= 0;
    else if (CE_I) hold_ff <= (SDA_OE_O && SCL_I == $past(SCL_I)) ? hold_ff + 1 : 0;
  end
  sequence fell_two_back;
    $past(SCL_I, 3) && !$past(SCL_I, 2);
  endsequence
  oe_timing_a: assert property (
    $changed(SDA_OE_O) && !WDT_FIRE_O && !$past(WDT_FIRE_O) |-> fell_two_back) else $error("oe timing");
  wr_pulse_a: assert property (WR_STB_O |=> !WR_STB_O) else $error("wr strobe");
  rd_pulse_a: assert property (RD_STB_O |=> !RD_STB_O) else $error("rd strobe");
  wdt_cause_a: assert property (WDT_FIRE_O |-> $past(WDT_EN_I) && $past(SDA_OE_O)) else $error("wdt cause");
  wdt_release_a: assert property (WDT_FIRE_O |-> ##[0:1] !SDA_OE_O) else $error("wdt release");
  wdt_pulse_a: assert property (WDT_FIRE_O |=> !WDT_FIRE_O) else $error("wdt pulse");
  wdt_bound_a: assert property (WDT_EN_I |-> hold_ff <= lim + 4) else $error("wdt late");
  wdt_early_a: assert property (WDT_FIRE_O |-> hold_ff + 4 >= lim) else $error("wdt early");
  sda_low_a: assert property (SDA_O == 1'b0) else $error("sda driven high");
  freeze_hold_a: assert property (!CE_I |=> $stable(SDA_OE_O) && $stable(WDT_FIRE_O)) else $error("freeze");
endmodule // iis_target_properties
bind iis_target iis_target_properties #(.WDT_SHORT(WDT_SHORT), .WDT_LONG(WDT_LONG)) i_props (.MCLK_I(MCLK_I),
  .RST_N_I(RST_N_I), .CE_I(CE_I), .SCL_I(SCL_I), .WDT_EN_I(WDT_EN_I), .WDT_SEL_I(WDT_SEL_I), .SDA_O(SDA_O),
  .SDA_OE_O(SDA_OE_O), .WR_STB_O(WR_STB_O), .RD_STB_O(RD_STB_O), .WDT_FIRE_O(WDT_FIRE_O));
`default_nettype wire

// >>> tb/iis_host.sv
`default_nettype none
module iis_host (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o = 1'b1,
  output logic sda_low_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Start when st is high, else stop followed by idle
  task automatic cond(input logic st, input int idle);
    tick(1);
    sda_low_o <= !st;
    tick(5);
    scl_o <= 1'b1;
    tick(6);
    sda_low_o <= st;
    tick(6);
    scl_o <= !st;
    tick(idle);
  endtask
  task automatic xfer(input logic [8:0] d, input int n, output logic [8:0] q);
    q = 9'h000;
    for (int i = 8; i > 8 - n; i--) begin
      tick(1);
      sda_low_o <= !d[i];
      tick(5);
      scl_o <= 1'b1;
      tick(6);
      q[i] = sda_i;
      scl_o <= 1'b0;
    end
    tick(1);
    sda_low_o <= 1'b0;
  endtask
endmodule // iis_host
`default_nettype wire

// >>> tb/imu_i2c_register_slave_bench.sv
`default_nettype none
module imu_i2c_register_slave_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] TRAP_REG = 8'h40;
  localparam logic [255:0] TRAP = 256'h1 << TRAP_REG;
  logic mclk = 1'b0, rst_n = 1'b0, asel = 1'b0, wdt_en = 1'b0, wdt_sel = 1'b0, ce = 1'b1;
  logic sda_oe, wr_stb, wdt_fire, scl, host_low, sda, sda_o, rd_stb;
  logic [7:0] reg_addr, wr_data, last_wa, last_wd;
  int err_count = 0, compares = 0, cyc = 0, rd_cnt = 0, fire_cnt = 0;
  integer seed = 32'h1E1C273C;
  function automatic logic [7:0] f(input logic [7:0] a);
    return a ^ 8'h5A;
  endfunction
  // Write address after one data byte: trap registers hold
  function automatic logic [7:0] wr_next(input logic [7:0] a);
    return TRAP[a] ? a : a + 8'h01;
  endfunction
  always #20 mclk = ~mclk;
  assign sda = !(host_low || sda_oe);
  iis_target #(.WDT_SHORT(50), .WDT_LONG(100), .TRAP_MASK(TRAP)) i_dut (.MCLK_I(mclk), .RST_N_I(rst_n), .CE_I(ce),
    .SCL_I(scl), .SDA_I(sda), .ADDR_SEL_I(asel), .WDT_EN_I(wdt_en), .WDT_SEL_I(wdt_sel), .RD_DATA_I(f(reg_addr)),
    .SDA_O(sda_o), .SDA_OE_O(sda_oe), .REG_ADDR_O(reg_addr), .WR_DATA_O(wr_data), .WR_STB_O(wr_stb),
    .RD_STB_O(rd_stb), .WDT_FIRE_O(wdt_fire));
  iis_host h (.clk_i(mclk), .sda_i(sda), .scl_o(scl), .sda_low_o(host_low));
  task automatic chk(input string n, input logic [8:0] e, input logic [8:0] s);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic results();
    $display("mismatches %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic xb(input string n, input logic [8:0] d, input logic [8:0] e, input logic [8:0] m);
    logic [8:0] q;
    h.xfer(d, 9, q);
    chk(n, e & m, q & m);
  endtask
  task automatic wph(input logic [6:0] dv, input logic [7:0] r);
    h.cond(1'b1, 0);
    xb("addr ack", {dv, 2'b01}, 9'h000, 9'h001);
    xb("reg ack", {r, 1'b1}, 9'h000, 9'h001);
  endtask
  task automatic rd(input logic [6:0] dv, input logic [7:0] a, input int n);
    int c0;
    c0 = rd_cnt;
    h.cond(1'b1, 0);
    xb("rd ack", {dv, 2'b11}, 9'h000, 9'h001);
    for (int i = 0; i < n; i++) begin
      xb("rd data", {8'hFF, 1'(i == n - 1)}, {f(a + 8'(i)), 1'b0}, 9'h1FE);
    end
    chk("rd strobes", 9'(n), 9'(rd_cnt - c0));
    h.cond(1'b0, iis_pkg::IDLE_NORMAL_CYC);
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (wr_stb === 1'b1) begin
      last_wa <= reg_addr;
      last_wd <= wr_data;
    end
    if (rd_stb === 1'b1) rd_cnt <= rd_cnt + 1;
    if (wdt_fire === 1'b1) fire_cnt <= fire_cnt + 1;
    if (cyc == 60000) begin
      err_count++;
      results();
    end
  end
  initial begin
    logic [8:0] q;
    logic [7:0] r, d;
    logic [6:0] dv;
    logic s;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    rd(iis_pkg::ADDR_SEL_LOW, iis_pkg::START_ADDR_RST, 2);
    for (int k = 0; k < 8; k++) begin
      s = 1'($random(seed));
      r = k == 0 ? 8'hFF : (k == 2 ? TRAP_REG : 8'($random(seed)));
      d = 8'($random(seed));
      asel <= s;
      dv = s ? iis_pkg::ADDR_SEL_HIGH : iis_pkg::ADDR_SEL_LOW;
      wph(dv, r);
      xb("data ack", {8'($random(seed)), 1'b1}, 9'h000, 9'h001);
      xb("data ack", {d, 1'b1}, 9'h000, 9'h001);
      h.cond(1'b0, k == 1 ? iis_pkg::IDLE_SUSPEND_CYC : iis_pkg::IDLE_NORMAL_CYC);
      chk("wr addr", {1'b0, wr_next(r)}, {1'b0, last_wa});
      chk("wr data", {1'b0, d}, {1'b0, last_wd});
      wph(dv, r);
      rd(dv, r, 3);
      h.cond(1'b1, 0);
      xb("foreign", {dv ^ 7'h01, 2'b01}, 9'h001, 9'h001);
      h.cond(1'b0, iis_pkg::IDLE_NORMAL_CYC);
      rd(dv, r, 1);
    end
    wdt_en <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      wdt_sel <= 1'(p);
      h.cond(1'b1, 0);
      h.xfer({dv, 2'b01}, 8, q);
      h.tick(8);
      chk("ack held", {6'h00, 2'(p), 1'b0}, {6'h00, 2'(fire_cnt), sda});
      if (p == 1) begin
        ce <= 1'b0;
        h.tick(100);
        ce <= 1'b1;
        h.tick(60);
        chk("wdt frozen", 9'h002, {6'h00, 2'(fire_cnt), sda});
      end
      h.tick(p == 1 ? 60 : 70);
      chk("wdt", {6'h00, 2'(p + 1), 1'b1}, {6'h00, 2'(fire_cnt), sda});
      h.cond(1'b0, 50);
    end
    chk("sda out", 9'h000, {8'h00, sda_o});
    results();
  end
endmodule // imu_i2c_register_slave_bench
`default_nettype wire
